/* File: src/pafd_top.sv */
// pointer address field decode: short and offset pointer fields to access addresses
//
// Functional notes
// - five-bit short field, mode bits, plain indirect
// - short base limited to registers four-seven
// - mode 000: address base, base plus first index
// - mode 001: address base, base plus second index
// - modes 010/011: base plus scaled index, no update
// - mode 101: address base, then base plus step
// - mode 110: address base, then base minus step
// - mode 111: base minus step, then address
// - step and shift come from access width
// - byte: step one, shift zero
// - sixteen-bit: step two, shift one
// - thirty-two-bit: step four, shift two
// - sixty-four-bit: step eight, shift three
// - short field only in listed instruction classes
// - twelve-bit offset field, immediate offset only
// - offset base any register zero to fourteen
// - address base plus immediate times four
// - stack pointer base unusable, flagged fault
// - offset field only word copy, two fields
// - alignment left to memory, not enforced here
`timescale 1ns/10ps
module pafd_top
  import pafd_pkg::*;
#(
  parameter int AW = PAFD_AW
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // request from instruction decode
  input wire logic REQ_VALID,
  input wire logic REQ_FORM,
  input wire logic [2:0] REQ_CLASS,
  input wire logic [1:0] REQ_SIZE,
  input wire logic [PAFD_SPF_W-1:0] REQ_SHORT_FIELD,
  input wire logic [PAFD_OPF_W-1:0] REQ_OFFSET_SRC,
  input wire logic [PAFD_OPF_W-1:0] REQ_OFFSET_DST,
  // address register file view
  input wire logic [PAFD_NREG-1:0][AW-1:0] AREG,
  // answer to data memory path
  output logic ADDR_VALID,
  output logic FAULT,
  output logic [AW-1:0] ADDR,
  output logic [AW-1:0] ADDR_DST,
  // base register write back
  output logic WB_EN,
  output logic [PAFD_RIDX_W-1:0] WB_IDX,
  output logic [AW-1:0] WB_DATA
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // offset reach needs ten address bits
  if (AW < 10)
  begin : g_chk
    $error("pafd_top: AW must be at least 10");
  end

  typedef struct packed {
    logic valid;
    logic fault;
    logic [AW-1:0] addr;
    logic [AW-1:0] addr_dst;
    logic wb_en;
    logic [PAFD_RIDX_W-1:0] wb_idx;
    logic [AW-1:0] wb_data;
  } pafd_state_t;

  pafd_state_t st_q;
  pafd_state_t st_d;

  pafd_agen_if #(.AW(AW)) ag ();

  pafd_agen #(.AW(AW)) u_agen (
    .ag(ag)
  );

  // ----------------------------------------------------------------
  // short field decode
  // ----------------------------------------------------------------
  logic [2:0] sh_mode;
  logic [1:0] sh_sel;
  logic [PAFD_RIDX_W-1:0] sh_base_idx;
  logic [PAFD_RIDX_W-1:0] sh_index_idx;
  logic [AW-1:0] sh_base_val;
  logic [AW-1:0] sh_index_val;
  logic [3:0] step;
  logic class_ok;

  assign sh_mode = REQ_SHORT_FIELD[SPF_MODE_MSB:SPF_MODE_LSB];
  assign sh_sel = REQ_SHORT_FIELD[SPF_SEL_MSB:SPF_SEL_LSB];
  assign sh_base_idx = SHORT_BASE_FIRST + {2'b00, sh_sel};
  // even modes use the first index register, odd the second
  assign sh_index_idx = REQ_SHORT_FIELD[SPF_MODE_LSB + SPF_IDX_BIT] ?
    SECOND_INDEX_REG : FIRST_INDEX_REG;
  assign sh_base_val = AREG[sh_base_idx];
  assign sh_index_val = AREG[sh_index_idx];

  // width code doubles as the shift; only the step needs a table
  always_comb
  begin
    step = STEP_8;
    unique case (REQ_SIZE)
      SIZE_8: step = STEP_8;
      SIZE_16: step = STEP_16;
      SIZE_32: step = STEP_32;
      SIZE_64: step = STEP_64;
    endcase
  end

  // loads only at 32/64, logic ops only at 32, stores and moves at any width
  always_comb
  begin
    class_ok = 1'b0;
    unique case (REQ_CLASS)
      CLS_LOAD: class_ok = (REQ_SIZE == SIZE_32) || (REQ_SIZE == SIZE_64);
      CLS_STORE: class_ok = 1'b1;
      CLS_MOVE: class_ok = 1'b1;
      CLS_LOGIC: class_ok = (REQ_SIZE == SIZE_32);
      default: class_ok = 1'b0;
    endcase
  end

  assign ag.mode = sh_mode;
  assign ag.base = sh_base_val;
  assign ag.index = sh_index_val;
  assign ag.shift = REQ_SIZE;
  assign ag.step = step;

  // ----------------------------------------------------------------
  // offset field decode
  // ----------------------------------------------------------------
  logic [PAFD_RIDX_W-1:0] src_idx;
  logic [PAFD_RIDX_W-1:0] dst_idx;
  logic [PAFD_IMM_W-1:0] src_imm;
  logic [PAFD_IMM_W-1:0] dst_imm;
  logic [AW-1:0] src_val;
  logic [AW-1:0] dst_val;
  logic [AW-1:0] src_addr;
  logic [AW-1:0] dst_addr;
  logic off_op_ok;
  logic off_sp;

  assign src_idx = REQ_OFFSET_SRC[OPF_BASE_MSB:OPF_BASE_LSB];
  assign dst_idx = REQ_OFFSET_DST[OPF_BASE_MSB:OPF_BASE_LSB];
  assign src_imm = REQ_OFFSET_SRC[OPF_IMM_MSB:OPF_IMM_LSB];
  assign dst_imm = REQ_OFFSET_DST[OPF_IMM_MSB:OPF_IMM_LSB];
  assign src_val = AREG[src_idx];
  assign dst_val = AREG[dst_idx];
  // unsigned offset, base never written back; base alignment is software's job
  assign src_addr = src_val + (AW'(src_imm) << OPF_IMM_SHIFT);
  assign dst_addr = dst_val + (AW'(dst_imm) << OPF_IMM_SHIFT);
  assign off_op_ok = (REQ_CLASS == CLS_MOVE) && (REQ_SIZE == SIZE_32);
  assign off_sp = (src_idx == STACK_POINTER_REG) || (dst_idx == STACK_POINTER_REG);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = '0;
    if (REQ_VALID)
    begin
      if (REQ_FORM == FORM_SHORT)
      begin
        if (class_ok)
        begin
          st_d.valid = 1'b1;
          st_d.addr = ag.addr;
          st_d.wb_en = ag.base_wr;
          st_d.wb_idx = sh_base_idx;
          st_d.wb_data = ag.new_base;
        end
        else
        begin
          st_d.fault = 1'b1;
        end
      end
      else
      begin
        if (off_op_ok && !off_sp)
        begin
          st_d.valid = 1'b1;
          st_d.addr = src_addr;
          st_d.addr_dst = dst_addr;
        end
        else
        begin
          st_d.fault = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // low address bits pass untouched; the target memory aligns
  assign ADDR = st_q.addr;
  assign ADDR_DST = st_q.addr_dst;
  assign ADDR_VALID = st_q.valid;
  assign FAULT = st_q.fault;
  assign WB_EN = st_q.wb_en;
  assign WB_IDX = st_q.wb_idx;
  assign WB_DATA = st_q.wb_data;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  logic sh_go;
  logic off_go;
  assign sh_go = REQ_VALID && (REQ_FORM == FORM_SHORT) && class_ok;
  assign off_go = REQ_VALID && (REQ_FORM == FORM_OFFSET);

  a_short_class: assert property (
    REQ_VALID && (REQ_FORM == FORM_SHORT) && !class_ok
    |=> FAULT && !ADDR_VALID && !WB_EN)
    else $error("short field accepted for a class that may not use it");

  a_post_index: assert property (
    sh_go && (sh_mode[2:1] == 2'b00)
    |=> ADDR_VALID && WB_EN && (ADDR == $past(sh_base_val))
    && (WB_DATA == $past(sh_base_val) + $past(sh_index_val)))
    else $error("post index update wrong");

  a_short_base: assert property (
    sh_go && (sh_mode == MODE_POST_INC)
    |=> WB_IDX == SHORT_BASE_FIRST + {2'b00, $past(sh_sel)})
    else $error("short base register number wrong");

  a_scaled_index: assert property (
    sh_go && (sh_mode[2:1] == 2'b01)
    |=> !WB_EN && (ADDR == $past(sh_base_val) + ($past(sh_index_val) << $past(REQ_SIZE))))
    else $error("scaled index address wrong");

  a_plain_ptr: assert property (
    sh_go && (sh_mode == MODE_PLAIN)
    |=> !WB_EN && (ADDR == $past(sh_base_val)))
    else $error("plain indirect address wrong");

  a_post_inc: assert property (
    sh_go && (sh_mode == MODE_POST_INC)
    |=> (ADDR == $past(sh_base_val))
    && (WB_DATA == $past(sh_base_val) + (AW'(1) << $past(REQ_SIZE))))
    else $error("post increment step wrong");

  a_post_dec: assert property (
    sh_go && (sh_mode == MODE_POST_DEC)
    |=> (ADDR == $past(sh_base_val))
    && (WB_DATA == $past(sh_base_val) - (AW'(1) << $past(REQ_SIZE))))
    else $error("post decrement step wrong");

  a_pre_dec: assert property (
    sh_go && (sh_mode == MODE_PRE_DEC)
    |=> WB_EN && (ADDR == WB_DATA)
    && (ADDR == $past(sh_base_val) - (AW'(1) << $past(REQ_SIZE))))
    else $error("pre decrement address wrong");

  a_offset_addr: assert property (
    off_go && off_op_ok && !off_sp
    |=> ADDR_VALID && !WB_EN
    && (ADDR == $past(src_val) + (AW'($past(src_imm)) << OPF_IMM_SHIFT))
    && (ADDR_DST == $past(dst_val) + (AW'($past(dst_imm)) << OPF_IMM_SHIFT)))
    else $error("offset pointer address wrong");

  a_offset_sp: assert property (
    off_go && off_sp
    |=> FAULT && !ADDR_VALID)
    else $error("stack pointer base not refused");

  a_offset_op: assert property (
    off_go && !off_op_ok
    |=> FAULT && !ADDR_VALID)
    else $error("offset field accepted outside word copy");

  a_idle_quiet: assert property (!REQ_VALID |=> !ADDR_VALID && !FAULT && !WB_EN)
    else $error("answer without request");

  c_post_index: cover property (sh_go && (sh_mode == MODE_POST_IDX1) ##1 WB_EN);
  c_pre_dec: cover property (sh_go && (sh_mode == MODE_PRE_DEC) && (REQ_SIZE == SIZE_64));
  c_offset_move: cover property (off_go && off_op_ok && !off_sp ##1 ADDR_VALID);
  c_fault: cover property (off_go && off_sp ##1 FAULT);
  c_scaled_idx: cover property (sh_go && (sh_mode == MODE_SCALED_IDX1) && (REQ_SIZE == SIZE_16));

endmodule

/* File: src/pafd_pkg.sv */
// package: field layouts, mode codes, size codes and instruction classes for pointer decode
package pafd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PAFD_AW = 32;
  localparam int PAFD_NREG = 16;
  localparam int PAFD_RIDX_W = 4;
  localparam int PAFD_SPF_W = 5;
  localparam int PAFD_OPF_W = 12;
  localparam int PAFD_IMM_W = 8;

  // ----------------------------------------------------------------
  // short pointer field layout
  // ----------------------------------------------------------------
  localparam int SPF_MODE_MSB = 4;
  localparam int SPF_MODE_LSB = 2;
  localparam int SPF_SEL_MSB = 1;
  localparam int SPF_SEL_LSB = 0;
  localparam int SPF_IDX_BIT = 0;
  localparam logic [3:0] SHORT_BASE_FIRST = 4'h4;

  // ----------------------------------------------------------------
  // offset pointer field layout
  // ----------------------------------------------------------------
  localparam int OPF_BASE_MSB = 11;
  localparam int OPF_BASE_LSB = 8;
  localparam int OPF_IMM_MSB = 7;
  localparam int OPF_IMM_LSB = 0;
  localparam int OPF_IMM_SHIFT = 2;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] FIRST_INDEX_REG = 4'h0;
  localparam logic [3:0] SECOND_INDEX_REG = 4'h1;
  localparam logic [3:0] STACK_POINTER_REG = 4'hF;

  // ----------------------------------------------------------------
  // short pointer modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_POST_IDX0 = 3'h0;
  localparam logic [2:0] MODE_POST_IDX1 = 3'h1;
  localparam logic [2:0] MODE_SCALED_IDX0 = 3'h2;
  localparam logic [2:0] MODE_SCALED_IDX1 = 3'h3;
  localparam logic [2:0] MODE_PLAIN = 3'h4;
  localparam logic [2:0] MODE_POST_INC = 3'h5;
  localparam logic [2:0] MODE_POST_DEC = 3'h6;
  localparam logic [2:0] MODE_PRE_DEC = 3'h7;

  // ----------------------------------------------------------------
  // access width codes (code is also the index shift)
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] SIZE_64 = 2'h3;
  localparam logic [3:0] STEP_8 = 4'h1;
  localparam logic [3:0] STEP_16 = 4'h2;
  localparam logic [3:0] STEP_32 = 4'h4;
  localparam logic [3:0] STEP_64 = 4'h8;

  // ----------------------------------------------------------------
  // instruction classes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLS_LOAD = 3'h0;
  localparam logic [2:0] CLS_STORE = 3'h1;
  localparam logic [2:0] CLS_MOVE = 3'h2;
  localparam logic [2:0] CLS_LOGIC = 3'h3;
  localparam logic [2:0] CLS_OTHER = 3'h4;

  // request forms
  localparam logic FORM_SHORT = 1'b0;
  localparam logic FORM_OFFSET = 1'b1;

endpackage

/* File: src/pafd_agen_if.sv */
// interface: decoded short pointer request and generated address between decode and adder
`timescale 1ns/10ps
interface pafd_agen_if #(
  parameter int AW = 32
);
  logic [2:0] mode;
  logic [AW-1:0] base;
  logic [AW-1:0] index;
  logic [1:0] shift;
  logic [3:0] step;
  logic [AW-1:0] addr;
  logic [AW-1:0] new_base;
  logic base_wr;

  modport dec (output mode, output base, output index, output shift, output step,
    input addr, input new_base, input base_wr);
  modport agen (input mode, input base, input index, input shift, input step,
    output addr, output new_base, output base_wr);
endinterface

/* File: src/pafd_agen.sv */
// short pointer address adder: access address and base update for the eight modes
`timescale 1ns/10ps
module pafd_agen
  import pafd_pkg::*;
#(
  parameter int AW = 32
)
(
  // decoded request and result
  pafd_agen_if.agen ag
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (AW < 8)
  begin : g_chk
    $error("pafd_agen: AW too small");
  end

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  always_comb
  begin
    ag.addr = ag.base;
    ag.new_base = ag.base;
    ag.base_wr = 1'b0;
    unique case (ag.mode)
      MODE_POST_IDX0, MODE_POST_IDX1:
      begin
        ag.new_base = ag.base + ag.index;
        ag.base_wr = 1'b1;
      end
      MODE_SCALED_IDX0, MODE_SCALED_IDX1:
      begin
        ag.addr = ag.base + (ag.index << ag.shift);
      end
      MODE_PLAIN:
      begin
        ag.addr = ag.base;
      end
      MODE_POST_INC:
      begin
        ag.new_base = ag.base + AW'(ag.step);
        ag.base_wr = 1'b1;
      end
      MODE_POST_DEC:
      begin
        ag.new_base = ag.base - AW'(ag.step);
        ag.base_wr = 1'b1;
      end
      MODE_PRE_DEC:
      begin
        ag.new_base = ag.base - AW'(ag.step);
        ag.addr = ag.base - AW'(ag.step);
        ag.base_wr = 1'b1;
      end
    endcase
  end

endmodule

/* File: bench/pafd_regfile_model.sv */
// model: address register file that feeds the decode and takes its base write backs
`timescale 1ns/10ps
module pafd_regfile_model
  import pafd_pkg::*;
(
  // clock
  input wire logic clk,
  // base write back from decode
  input wire logic wb_en,
  input wire logic [PAFD_RIDX_W-1:0] wb_idx,
  input wire logic [PAFD_AW-1:0] wb_data,
  // preload from bench
  input wire logic set_en,
  input wire logic [PAFD_RIDX_W-1:0] set_idx,
  input wire logic [PAFD_AW-1:0] set_val,
  // contents seen by decode
  output logic [PAFD_NREG-1:0][PAFD_AW-1:0] areg
);
  // no reset: contents survive a decode reset, so a reset in mid-run keeps the shadow valid
  initial areg = '0;
  always @(posedge clk)
  begin
    if (set_en)
      areg[set_idx] <= set_val;
    // write lands one edge after the answer, so a request after one idle cycle sees the new base
    if (wb_en)
      areg[wb_idx] <= wb_data;
  end
endmodule

/* File: bench/pointer_address_field_decode_test.sv */
// testbench: directed checks of short and offset pointer address decode
`timescale 1ns/10ps
module pointer_address_field_decode_test
  import pafd_pkg::*;
;
  localparam time DLY = 1;
  localparam int LIMIT = 2000;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic REQ_VALID = 1'b0;
  logic REQ_FORM = 1'b0;
  logic [2:0] REQ_CLASS = '0;
  logic [1:0] REQ_SIZE = '0;
  logic [4:0] REQ_SHORT_FIELD = '0;
  logic [11:0] REQ_OFFSET_SRC = '0;
  logic [11:0] REQ_OFFSET_DST = '0;
  logic [15:0][31:0] AREG;
  logic ADDR_VALID, FAULT, WB_EN;
  logic [31:0] ADDR, ADDR_DST, WB_DATA;
  logic [3:0] WB_IDX;
  logic set_en = 1'b0;
  logic [3:0] set_idx = '0;
  logic [31:0] set_val = '0;
  logic [31:0] sh [16];
  logic e_flt, e_we;
  logic [31:0] e_a, e_d, e_wd;
  logic [3:0] e_wi;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 CLK = ~CLK;

  pafd_top #(.AW(PAFD_AW)) u_dut (.CLK(CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
    .REQ_FORM(REQ_FORM), .REQ_CLASS(REQ_CLASS), .REQ_SIZE(REQ_SIZE),
    .REQ_SHORT_FIELD(REQ_SHORT_FIELD), .REQ_OFFSET_SRC(REQ_OFFSET_SRC),
    .REQ_OFFSET_DST(REQ_OFFSET_DST), .AREG(AREG), .ADDR_VALID(ADDR_VALID), .FAULT(FAULT),
    .ADDR(ADDR), .ADDR_DST(ADDR_DST), .WB_EN(WB_EN), .WB_IDX(WB_IDX), .WB_DATA(WB_DATA));
  pafd_regfile_model u_model (.clk(CLK), .wb_en(WB_EN), .wb_idx(WB_IDX), .wb_data(WB_DATA),
    .set_en(set_en), .set_idx(set_idx), .set_val(set_val), .areg(AREG));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge CLK);
    #DLY;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic short_req(input logic [2:0] cls, input logic [1:0] sz, input logic [2:0] m,
    input logic [1:0] sel);
    logic [31:0] b;
    logic [31:0] x;
    b = sh[4 + sel];
    x = sh[{3'h0, m[0]}];
    REQ_FORM = FORM_SHORT;
    REQ_CLASS = cls;
    REQ_SIZE = sz;
    REQ_SHORT_FIELD = {m, sel};
    e_flt = cls >= 3'h4 || (cls == CLS_LOAD && sz < 2'h2) || (cls == CLS_LOGIC && sz != 2'h2);
    e_d = '0;
    e_a = b;
    e_we = !e_flt && (m < 3'h2 || m > 3'h4);
    // accepted short requests name the base and carry it even when not written back
    e_wi = e_flt ? 4'h0 : 4'h4 + {2'h0, sel};
    e_wd = b;
    case (m)
      3'h0, 3'h1: e_wd = b + x;
      3'h2, 3'h3: e_a = b + (x << sz);
      3'h5: e_wd = b + (32'h1 << sz);
      3'h6, 3'h7: e_wd = b - (32'h1 << sz);
      default: e_wd = b;
    endcase
    if (m == 3'h7)
      e_a = e_wd;
    if (e_flt)
    begin
      e_a = '0;
      e_wd = '0;
    end
  endtask

  task automatic off_req(input logic [2:0] cls, input logic [1:0] sz, input logic [11:0] src,
    input logic [11:0] dst);
    REQ_FORM = FORM_OFFSET;
    REQ_CLASS = cls;
    REQ_SIZE = sz;
    REQ_OFFSET_SRC = src;
    REQ_OFFSET_DST = dst;
    e_flt = !(cls == CLS_MOVE && sz == SIZE_32) || src[11:8] == 4'hF || dst[11:8] == 4'hF;
    e_a = e_flt ? '0 : sh[src[11:8]] + {22'h0, src[7:0], 2'h0};
    e_d = e_flt ? '0 : sh[dst[11:8]] + {22'h0, dst[7:0], 2'h0};
    e_we = 1'b0;
    e_wi = '0;
    e_wd = '0;
  endtask

  // one request, answer judged in the cycle it stands, then one idle cycle
  task automatic go();
    REQ_VALID = 1'b1;
    tick();
    REQ_VALID = 1'b0;
    chk("ADDR_VALID", {31'h0, ~e_flt}, {31'h0, ADDR_VALID});
    chk("FAULT", {31'h0, e_flt}, {31'h0, FAULT});
    chk("ADDR", e_a, ADDR);
    chk("ADDR_DST", e_d, ADDR_DST);
    chk("WB_EN", {31'h0, e_we}, {31'h0, WB_EN});
    chk("WB_IDX", {28'h0, e_wi}, {28'h0, WB_IDX});
    chk("WB_DATA", e_wd, WB_DATA);
    if (e_we)
      sh[e_wi] = e_wd;
    tick();
    chk("idle flags", 32'h0, {31'h0, ADDR_VALID | FAULT});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_offset();
    logic [7:0] imm;
    for (int b = 0; b < 15; b++)
    begin
      imm = (b == 14) ? 8'hFF : 8'(b * 17);
      off_req(CLS_MOVE, SIZE_32, {4'(b), imm}, {4'(14 - b), ~imm});
      go();
    end
    off_req(CLS_MOVE, SIZE_32, 12'hF10, 12'h304);
    go();
    off_req(CLS_MOVE, SIZE_32, 12'h208, 12'hF01);
    go();
    $display("test offset done");
  endtask

  task automatic t_classes();
    for (int c = 0; c < 8; c++)
      for (int s = 0; s < 4; s++)
      begin
        short_req(3'(c), 2'(s), MODE_PLAIN, 2'(s));
        go();
        off_req(3'(c), 2'(s), 12'h320, 12'h902);
        go();
      end
    $display("test classes done");
  endtask

  task automatic t_modes();
    for (int s = 0; s < 4; s++)
      for (int m = 0; m < 8; m++)
      begin
        short_req(CLS_STORE, 2'(s), 3'(m), 2'(m + s));
        go();
      end
    $display("test modes done");
  endtask

  task automatic t_b2b();
    short_req(CLS_MOVE, SIZE_16, MODE_POST_INC, 2'h0);
    REQ_VALID = 1'b1;
    tick();
    chk("b2b first ADDR", e_a, ADDR);
    chk("b2b first WB_DATA", e_wd, WB_DATA);
    sh[4] = e_wd;
    short_req(CLS_LOAD, SIZE_64, MODE_PRE_DEC, 2'h1);
    tick();
    REQ_VALID = 1'b0;
    chk("b2b second ADDR", e_a, ADDR);
    chk("b2b second WB_IDX", 32'h5, {28'h0, WB_IDX});
    sh[5] = e_wd;
    tick();
    chk("b2b idle ADDR", 32'h0, ADDR);
    $display("test back to back done");
  endtask

  task automatic t_reset();
    short_req(CLS_STORE, SIZE_8, MODE_PLAIN, 2'h2);
    REQ_VALID = 1'b1;
    tick();
    chk("pre reset ADDR_VALID", 32'h1, {31'h0, ADDR_VALID});
    // reset lands while an answer stands, so the clear is visible
    RST_B = 1'b0;
    #5;
    chk("reset ADDR_VALID", 32'h0, {31'h0, ADDR_VALID});
    chk("reset standing ADDR", 32'h0, ADDR);
    tick();
    chk("reset ADDR", 32'h0, ADDR);
    RST_B = 1'b1;
    tick();
    REQ_VALID = 1'b0;
    chk("post reset ADDR_VALID", 32'h1, {31'h0, ADDR_VALID});
    chk("post reset ADDR", e_a, ADDR);
    tick();
    $display("test reset done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    // preload takes the sixteen reset cycles; bases start word aligned
    for (int i = 0; i < 16; i++)
    begin
      sh[i] = (i < 2) ? 32'h0000_0014 - 32'(i * 8) : 32'h1000_0000 + 32'(i * 64);
      set_en = 1'b1;
      set_idx = 4'(i);
      set_val = sh[i];
      tick();
    end
    set_en = 1'b0;
    RST_B = 1'b1;
    t_offset();
    t_classes();
    t_modes();
    t_b2b();
    t_reset();
    tally_and_finish();
  end

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
endmodule
